// [bench/fpc_panel_ctrl_tb.sv]
`timescale 1ns/1ps
`include "fpc_cfg.svh"
`define CHK(g, e) \
    begin \
        checks++; \
        if ((g) !== (e)) \
        begin \
            failCount++; \
            $display("mismatch t=%0t got %0h exp %0h", $time, (g), (e)); \
        end \
    end
module fpc_panel_ctrl_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] ioAddr = 16'h0000;
    logic ioWr = 1'b0;
    logic ioRd = 1'b0;
    logic standbyPinN = 1'b1;
    logic ref32kPin = 1'b0;
    logic lpNeg = 1'b0;
    logic clrCount = 1'b0;
    logic [7:0] ioWrData = 8'h00;
    logic [7:0] pixIn = 8'hA5;
    logic [7:0] hDispEnd = 8'h28;
    logic [7:0] hPanelSize = 8'h50;
    logic [3:0] miscClkSel = 4'hC;
    logic [1:0] miscSyncPol = 2'b11;
    logic [1:0] featClkSel = 2'b11;
    fpc_pkg::fpc_timing_t timIn = '0;
    logic [7:0] ioRdData, pixOut, pixWire, r;
    logic pixOe, blankOut, linePulseOut, framePulseOut, ctlOe, weakPullDown;
    logic hostStop, videoStop, refreshReq, selfRefresh, lineGfx, ninthCopy, frcStep;
    logic hComp, hAutoCenter, textCompress, force8Dot, hDouble, shiftClkMask;
    logic [3:0] dotClkSel;
    logic [1:0] crtSyncPol;
    logic [8:0] leftBorder;
    logic [15:0] lineCount;
    logic [2:0] p;
    fpc_pkg::fpc_pack_t packMode;
    fpc_pkg::fpc_vplan_t vPlan;
    int checks = 0;
    int failCount = 0;
    int cycles = 0;
    int frcCount = 0;
    int refCount = 0;
    int c0;

    fpc_panel_ctrl i_dut (.clk, .sys_rst, .ioAddr, .ioWr, .ioRd, .ioWrData, .ioRdData,
        .standbyPinN, .ref32kPin, .tim(timIn), .hDispEnd, .hPanelSize, .miscClkSel,
        .miscSyncPol, .featClkSel, .pixIn, .pixOut, .pixOe, .blankOut, .linePulseOut,
        .framePulseOut, .ctlOe, .weakPullDown, .hostStop, .videoStop, .refreshReq,
        .selfRefresh, .dotClkSel, .crtSyncPol, .shiftClkMask, .lineGfx, .ninthCopy,
        .packMode, .frcStep, .hComp, .hAutoCenter, .leftBorder, .textCompress,
        .force8Dot, .hDouble, .vPlan);
    fpc_panel_model i_panel (.clk, .sys_rst, .pixOut, .pixOe, .linePulseOut, .ctlOe,
        .weakPullDown, .lpNeg, .clrCount, .pixWire, .lineCount);

    // 100 MHz dot clock
    always #5 clk = ~clk;
    // pulse tallies and hang guard
    always @(posedge clk)
    begin
        cycles++;
        frcCount += int'(frcStep);
        refCount += int'(refreshReq);
        if (cycles == 5000)
        begin
            failCount++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, failCount);
        if (failCount == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // index then data, outputs settle two edges after the data write
    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        @(posedge clk);
        ioWr <= 1'b1;
        ioAddr <= 16'h03D6;
        ioWrData <= idx;
        @(posedge clk);
        ioAddr <= 16'h03D7;
        ioWrData <= val;
        @(posedge clk);
        ioWr <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] idx, output logic [7:0] val);
        @(posedge clk);
        ioWr <= 1'b1;
        ioAddr <= 16'h03D6;
        ioWrData <= idx;
        @(posedge clk);
        ioWr <= 1'b0;
        ioRd <= 1'b1;
        ioAddr <= 16'h03D7;
        @(posedge clk);
        ioRd <= 1'b0;
        #1 val = ioRdData;
    endtask
    // n blank periods on the horizontal or vertical strobe
    task automatic strobe(input bit vert, input int n);
        @(posedge clk) clrCount <= 1'b1;
        @(posedge clk) clrCount <= 1'b0;
        repeat (n)
        begin
            @(posedge clk);
            if (vert)
                timIn.vBlank <= 1'b1;
            else
                timIn.hBlank <= 1'b1;
            repeat (4) @(posedge clk);
            if (vert)
                timIn.vBlank <= 1'b0;
            else
                timIn.hBlank <= 1'b0;
            repeat (4) @(posedge clk);
        end
        #1;
    endtask

    initial
    begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk) #1;
        `CHK(pixOe, 1'b0);
        `CHK(pixWire, 8'h00);
        `CHK(dotClkSel, 4'hF);
        `CHK(crtSyncPol, 2'b11);
        for (int i = 8'h53; i <= 8'h58; i++)
        begin
            wr(8'(i), 8'(i) ^ 8'hFC);
            rd(8'(i), r);
            `CHK(r, 8'(i) ^ 8'hFC);
            wr(8'(i), i == 8'h53 ? 8'h0C : 8'h00);
        end
        wr(8'h40, 8'h5A);
        rd(8'h40, r);
        `CHK(r, 8'h00);
        wr(`FPC_IX_PWR, 8'h80);
        `CHK({ctlOe, weakPullDown, pixOe, pixOut, blankOut}, 12'hA00);
        $display("test registers and crt pins done");
        wr(`FPC_IX_DISP, 8'h24);
        `CHK({pixOe, ctlOe, blankOut, linePulseOut, framePulseOut}, 5'h1C);
        `CHK(pixOut, pixIn);
        `CHK({dotClkSel, crtSyncPol}, 6'h00);
        wr(`FPC_IX_PIF, 8'hC1);
        `CHK({blankOut, linePulseOut, framePulseOut}, 3'b011);
        wr(`FPC_IX_PIF, 8'h3C);
        wr(`FPC_IX_HCMP, 8'hC0);
        `CHK({dotClkSel, crtSyncPol}, 6'h3F);
        $display("test panel pins done");
        wr(`FPC_IX_PIF, 8'h00);
        @(posedge clk) timIn.vBlank <= 1'b1;
        strobe(0, 4);
        `CHK({shiftClkMask, lineCount}, 17'h10000);
        wr(`FPC_IX_PIF, 8'h02);
        strobe(0, 4);
        `CHK({shiftClkMask, lineCount}, 17'h00004);
        @(posedge clk) timIn.vBlank <= 1'b0;
        wr(`FPC_IX_PIF, 8'h40);
        @(posedge clk) lpNeg <= 1'b1;
        strobe(0, 3);
        `CHK(lineCount, 16'h0003);
        $display("test line pulses done");
        @(posedge clk) timIn.frcTwoFrame <= 1'b1;
        wr(`FPC_IX_FMT3, 8'h4C);
        c0 = frcCount;
        strobe(1, 4);
        `CHK(frcCount - c0, 2);
        wr(`FPC_IX_FMT3, 8'h0C);
        c0 = frcCount;
        strobe(1, 4);
        `CHK(frcCount - c0, 4);
        for (p = 3'd0; p < 3'd4; p++)
        begin
            wr(`FPC_IX_FMT3, {2'b00, p[1:0], 4'hC});
            `CHK(packMode, p[1:0]);
        end
        @(posedge clk) timIn.attrLineGfx <= 1'b1;
        wr(`FPC_IX_FMT3, 8'h0C);
        `CHK({lineGfx, ninthCopy}, 2'b10);
        wr(`FPC_IX_FMT3, 8'h0D);
        `CHK({lineGfx, ninthCopy}, 2'b00);
        wr(`FPC_IX_FMT3, 8'h0F);
        `CHK({lineGfx, ninthCopy}, 2'b11);
        $display("test format options done");
        wr(`FPC_IX_HLB, 8'hFF);
        wr(`FPC_IX_HCMP, 8'h01);
        `CHK(hComp, 1'b0);
        wr(`FPC_IX_DISP, 8'h44);
        `CHK({hComp, hAutoCenter, leftBorder}, 11'h500);
        @(posedge clk) timIn <= '{textMode: 1'b1, nineDot: 1'b1, default: 1'b0};
        wr(`FPC_IX_HCMP, 8'h07);
        `CHK({hAutoCenter, textCompress, force8Dot}, 3'b111);
        wr(`FPC_IX_HCMP, 8'h21);
        `CHK(hDouble, 1'b1);
        @(posedge clk) hDispEnd <= 8'h29;
        repeat (3) @(posedge clk) #1;
        `CHK(hDouble, 1'b0);
        @(posedge clk) timIn.seqDouble <= 1'b1;
        repeat (3) @(posedge clk) #1;
        `CHK(hDouble, 1'b1);
        wr(`FPC_IX_VCTR, 8'h03);
        wr(`FPC_IX_VCMP, 8'h01);
        `CHK(vPlan, 8'h81);
        wr(`FPC_IX_VCMP, 8'h03);
        `CHK(vPlan, 8'hC1);
        wr(`FPC_IX_VCMP, 8'h7F);
        `CHK(vPlan, 8'hFF);
        wr(`FPC_IX_VCMP, 8'hFF);
        `CHK(vPlan, 8'hFE);
        wr(`FPC_IX_VCTR, 8'h02);
        wr(`FPC_IX_VCMP, 8'h00);
        wr(`FPC_IX_HCMP, 8'h00);
        `CHK({hComp, textCompress, hDouble, vPlan}, 11'h000);
        `CHK(pixOut, pixIn);
        $display("test compensation done");
        wr(`FPC_IX_SRDIV, 8'h02);
        wr(`FPC_IX_PWR, 8'h40);
        @(posedge clk) standbyPinN <= 1'b0;
        repeat (4) @(posedge clk) #1;
        `CHK({hostStop, videoStop, pixOe, ctlOe}, 4'hC);
        c0 = refCount;
        repeat (6)
        begin
            @(posedge clk) ref32kPin <= 1'b1;
            repeat (8) @(posedge clk) ref32kPin <= 1'b0;
            repeat (8) @(posedge clk);
        end
        `CHK(refCount - c0, 2);
        wr(`FPC_IX_HLB, 8'h11);
        @(posedge clk) standbyPinN <= 1'b1;
        repeat (4) @(posedge clk);
        rd(`FPC_IX_HLB, r);
        `CHK(r, 8'hFF);
        wr(`FPC_IX_PWR, 8'h00);
        @(posedge clk) standbyPinN <= 1'b0;
        repeat (4) @(posedge clk) #1;
        `CHK(selfRefresh, 1'b1);
        $display("test standby done");
        conclude();
    end
endmodule

// [bench/fpc_panel_model.sv]
`timescale 1ns/1ps
module fpc_panel_model (
    input wire logic clk, // dot clock
    input wire logic sys_rst, // async reset
    input wire logic [7:0] pixOut, // data from controller
    input wire logic pixOe, // data enable
    input wire logic linePulseOut, // line pulse level
    input wire logic ctlOe, // control enable
    input wire logic weakPullDown, // pull-down active
    input wire logic lpNeg, // line pulse active low
    input wire logic clrCount, // restart pulse count
    output logic [7:0] pixWire, // resolved data pins
    output logic [15:0] lineCount // line pulses seen
);
    logic [7:0] lastPix;
    // undriven pins without pull-down drift, so show inverted stale data
    always_comb
    begin
        if (pixOe)
            pixWire = pixOut;
        else if (weakPullDown)
            pixWire = 8'h00;
        else
            pixWire = ~lastPix;
    end
    // last value the controller drove
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            lastPix <= 8'h00;
        else if (pixOe)
            lastPix <= pixOut;
    end
    // panel latches a row per active line strobe while controls are driven
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            lineCount <= 16'h0000;
        else if (clrCount || (ctlOe && (linePulseOut ^ lpNeg)))
            lineCount <= clrCount ? 16'h0000 : lineCount + 16'h0001;
    end
endmodule

// [core/fpc_cfg.svh]
`ifndef FPC_CFG_SVH
`define FPC_CFG_SVH
// Contract
// R1 - standby pin low halts host, video, tri-states
// R2 - standby refresh: self-refresh or paced divider
// R3 - crt-only: tri-state pulled down, or inactive
// R4 - line graphics from attribute or format-3 bit
// R5 - ninth pixel background or copy of eighth
// R6 - software writes ones to option bits 2,3
// R7 - two-bit stn packing field selects packing
// R8 - software restricts shift clock divide per packing
// R9 - two-frame frc steps each or alternate frame
// R10 - blank pin polarity from interface bit 0
// R11 - combined blank; no line pulses in vblank
// R12 - hblank only; line pulses continue in vblank
// R13 - panel dot clock source from interface bits
// R14 - line and frame pulse polarity bits 6,7
// R15 - horizontal compensation gated; manual or auto center
// R16 - text compression forces 8-dot and 8-bit panning
// R17 - horizontal doubling from mode or half width
// R18 - panel mode crt sync polarity from comp bits
// R19 - left border equals value plus one
// R20 - vertical centering manual or automatic
// R21 - text stretch priority from two-bit field
// R22 - replication stretch order from bit 6
// R23 - fast centering only when centering field 11
// R24 - display type bit 2 selects crt or panel
// R25 - all enables clear passes timing unmodified
`define FPC_IDX_PORT 16'h03D6
`define FPC_DATA_PORT 16'h03D7
`define FPC_IX_DISP 8'h51
`define FPC_IX_PWR 8'h52
`define FPC_IX_FMT3 8'h53
`define FPC_IX_PIF 8'h54
`define FPC_IX_HCMP 8'h55
`define FPC_IX_HLB 8'h56
`define FPC_IX_VCMP 8'h57
`define FPC_IX_VCTR 8'h58
`define FPC_IX_SRDIV 8'h5F
`define FPC_REG_RST 8'h00
`define FPC_B_FPMODE 2
`define FPC_B_SMASK 5
`define FPC_B_EFCP 6
`define FPC_B_SWSTBY 4
`define FPC_B_REFSEL 6
`define FPC_B_CRTCTL 7
`define FPC_B_FRC3 6
`define FPC_B_HOLD 7
`define FPC_SYNC_INIT 2'b11
`endif

// [core/fpc_panel_ctrl.sv]
`timescale 1ns/1ps
`include "fpc_cfg.svh"
module fpc_panel_ctrl (
    input wire logic clk, // dot clock
    input wire logic sys_rst, // async reset
    input wire logic [15:0] ioAddr, // host i/o address
    input wire logic ioWr, // host write strobe
    input wire logic ioRd, // host read strobe
    input wire logic [7:0] ioWrData, // host write data
    output logic [7:0] ioRdData, // host read data
    input wire logic standbyPinN, // standby pin, low active
    input wire logic ref32kPin, // 32 kHz refresh reference
    input wire fpc_pkg::fpc_timing_t tim, // timing strobes
    input wire logic [7:0] hDispEnd, // horizontal display end
    input wire logic [7:0] hPanelSize, // horizontal panel size
    input wire logic [3:0] miscClkSel, // misc output clock bits
    input wire logic [1:0] miscSyncPol, // misc output sync pol
    input wire logic [1:0] featClkSel, // feature control bits
    input wire logic [7:0] pixIn, // panel data from pipeline
    output logic [7:0] pixOut, // panel data pins
    output logic pixOe, // panel data enable
    output logic blankOut, // blank pin value
    output logic linePulseOut, // panel_line_pulse value
    output logic framePulseOut, // panel_frame_pulse value
    output logic ctlOe, // panel control enable
    output logic weakPullDown, // weak pull-down request
    output logic hostStop, // host memory path halted
    output logic videoStop, // video, timing, dac halted
    output logic refreshReq, // paced refresh pulse
    output logic selfRefresh, // self-refresh mode
    output logic [3:0] dotClkSel, // dot clock source
    output logic [1:0] crtSyncPol, // crt sync polarity
    output logic shiftClkMask, // mask shift clock now
    output logic lineGfx, // line graphics active
    output logic ninthCopy, // ninth pixel copies eighth
    output fpc_pkg::fpc_pack_t packMode, // stn packing
    output logic frcStep, // frc data advance pulse
    output logic hComp, // horizontal compensation on
    output logic hAutoCenter, // automatic horizontal centering
    output logic [8:0] leftBorder, // left border, char clocks
    output logic textCompress, // text compression on
    output logic force8Dot, // 8-dot chars, 8-bit panning
    output logic hDouble, // horizontal pixel doubling
    output fpc_pkg::fpc_vplan_t vPlan // vertical plan
);
    logic [7:0] idx_reg;
    logic [7:0] disp_reg;
    logic [7:0] pwr_reg;
    logic [7:0] fmt3_reg;
    logic [7:0] pif_reg;
    logic [7:0] hcmp_reg;
    logic [7:0] hlb_reg;
    logic [7:0] vcmp_reg;
    logic [7:0] vctr_reg;
    logic [7:0] srdiv_reg;
    logic [1:0] stbySync;
    logic [2:0] refSync;
    logic standby;
    logic panelMode;
    logic dataWr;
    logic fpBlank;
    logic hBlankPrev;
    logic blankPrev;
    logic vBlankPrev;
    logic lpRaw;
    logic flmRaw;
    logic frcPhase_reg;
    fpc_pkg::fpc_vid_t vidMode;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // pins from outside pass two flops first
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stbySync <= `FPC_SYNC_INIT;
            refSync <= 3'h0;
        end
        else
        begin
            stbySync <= {stbySync[0], standbyPinN};
            refSync <= {refSync[1:0], ref32kPin};
        end
    end

    assign standby = !stbySync[1] || pwr_reg[`FPC_B_SWSTBY];
    assign panelMode = disp_reg[`FPC_B_FPMODE]; // [R24]
    assign hostStop = standby; // [R1]
    assign videoStop = standby; // [R1]
    // host is ignored while in standby
    assign dataWr = ioWr && !standby && ioAddr == `FPC_DATA_PORT; // [R1]

    // index port
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            idx_reg <= `FPC_REG_RST;
        end
        else if (ioWr && !standby && ioAddr == `FPC_IDX_PORT) // [R1]
        begin
            idx_reg <= ioWrData;
        end
    end

    // indexed register writes
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            disp_reg <= `FPC_REG_RST;
            fmt3_reg <= `FPC_REG_RST;
            pif_reg <= `FPC_REG_RST;
            hcmp_reg <= `FPC_REG_RST;
            hlb_reg <= `FPC_REG_RST;
            vcmp_reg <= `FPC_REG_RST;
            vctr_reg <= `FPC_REG_RST;
            srdiv_reg <= `FPC_REG_RST;
        end
        else if (dataWr)
        begin
            case (idx_reg)
                `FPC_IX_DISP: disp_reg <= ioWrData;
                `FPC_IX_FMT3: fmt3_reg <= ioWrData;
                `FPC_IX_PIF: pif_reg <= ioWrData;
                `FPC_IX_HCMP: hcmp_reg <= ioWrData;
                `FPC_IX_HLB: hlb_reg <= ioWrData;
                `FPC_IX_VCMP: vcmp_reg <= ioWrData;
                `FPC_IX_VCTR: vctr_reg <= ioWrData;
                `FPC_IX_SRDIV: srdiv_reg <= ioWrData;
                default: ;
            endcase
        end
    end

    // software standby bit drops when the pin goes low; pin wins
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pwr_reg <= `FPC_REG_RST;
        end
        else if (!stbySync[1])
        begin
            pwr_reg[`FPC_B_SWSTBY] <= 1'b0;
        end
        else if (dataWr && idx_reg == `FPC_IX_PWR)
        begin
            pwr_reg <= ioWrData;
        end
    end

    // read back; unknown index reads zero
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ioRdData <= 8'h00;
        end
        else if (ioRd && !standby && ioAddr == `FPC_IDX_PORT)
        begin
            ioRdData <= idx_reg;
        end
        else if (ioRd && !standby && ioAddr == `FPC_DATA_PORT)
        begin
            case (idx_reg)
                `FPC_IX_DISP: ioRdData <= disp_reg;
                `FPC_IX_PWR: ioRdData <= pwr_reg;
                `FPC_IX_FMT3: ioRdData <= fmt3_reg;
                `FPC_IX_PIF: ioRdData <= pif_reg;
                `FPC_IX_HCMP: ioRdData <= hcmp_reg;
                `FPC_IX_HLB: ioRdData <= hlb_reg;
                `FPC_IX_VCMP: ioRdData <= vcmp_reg;
                `FPC_IX_VCTR: ioRdData <= vctr_reg;
                `FPC_IX_SRDIV: ioRdData <= srdiv_reg;
                default: ioRdData <= 8'h00;
            endcase
        end
    end

    // standby memory refresh pacing
    fpc_refresh_pacer u_pacer (
        .clk(clk),
        .sys_rst(sys_rst),
        .standby(standby),
        .paced(pwr_reg[`FPC_B_REFSEL]),
        .srcTick(refSync[1] && !refSync[2]),
        .divider(srdiv_reg[3:0]),
        .refreshReq(refreshReq),
        .selfRefresh(selfRefresh)
    ); // [R2]

    // pin drive mode; standby always floats the pins
    always_comb
    begin
        vidMode = fpc_pkg::VID_DRIVE;
        if (standby)
        begin
            vidMode = fpc_pkg::VID_FLOAT; // [R1]
        end
        else if (!panelMode)
        begin
            vidMode = pwr_reg[`FPC_B_CRTCTL] ? fpc_pkg::VID_INACTIVE
                : fpc_pkg::VID_FLOAT; // [R3]
        end
    end

    // blank content: combined or horizontal only
    assign fpBlank = pif_reg[1] ? tim.hBlank : (tim.hBlank || tim.vBlank); // [R11] [R12]
    // line pulse on the inactive edge of the selected blank
    assign lpRaw = pif_reg[1] ? (hBlankPrev && !tim.hBlank)
        : (blankPrev && !fpBlank); // [R11] [R12]
    assign flmRaw = vBlankPrev && !tim.vBlank;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            hBlankPrev <= 1'b0;
            blankPrev <= 1'b0;
            vBlankPrev <= 1'b0;
        end
        else
        begin
            hBlankPrev <= tim.hBlank;
            blankPrev <= fpBlank;
            vBlankPrev <= tim.vBlank;
        end
    end

    // panel pins: inactive level is the deasserted pulse polarity; the blank pin sits at its blanking level
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pixOut <= 8'h00;
            pixOe <= 1'b0;
            ctlOe <= 1'b0;
            weakPullDown <= 1'b1;
            blankOut <= 1'b0;
            linePulseOut <= 1'b0;
            framePulseOut <= 1'b0;
            shiftClkMask <= 1'b0;
        end
        else
        begin
            pixOe <= vidMode != fpc_pkg::VID_FLOAT; // [R1] [R3]
            ctlOe <= vidMode != fpc_pkg::VID_FLOAT; // [R1] [R3]
            weakPullDown <= vidMode == fpc_pkg::VID_FLOAT; // [R3]
            if (vidMode == fpc_pkg::VID_DRIVE)
            begin
                pixOut <= pixIn; // [R25]
                blankOut <= (!fpBlank) ^ pif_reg[0]; // [R10]
                linePulseOut <= lpRaw ^ pif_reg[6]; // [R14]
                framePulseOut <= flmRaw ^ pif_reg[7]; // [R14]
                shiftClkMask <= disp_reg[`FPC_B_SMASK] && fpBlank; // [R12]
            end
            else
            begin
                pixOut <= 8'h00;
                blankOut <= pif_reg[0];
                linePulseOut <= pif_reg[6];
                framePulseOut <= pif_reg[7];
                shiftClkMask <= 1'b0;
            end
        end
    end

    // clock source and crt sync polarity override in panel mode
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dotClkSel <= 4'h0;
            crtSyncPol <= 2'b00;
        end
        else
        begin
            dotClkSel <= panelMode ? {pif_reg[5:4], pif_reg[3:2]}
                : {featClkSel, miscClkSel[3:2]}; // [R13]
            crtSyncPol <= panelMode ? hcmp_reg[7:6] : miscSyncPol; // [R18]
        end
    end

    // line graphics source, ninth pixel and packing
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            lineGfx <= 1'b0;
            ninthCopy <= 1'b0;
            packMode <= fpc_pkg::PACK3;
        end
        else
        begin
            lineGfx <= fmt3_reg[0] ? fmt3_reg[1] : tim.attrLineGfx; // [R4]
            ninthCopy <= fmt3_reg[0] && fmt3_reg[1]; // [R5]
            packMode <= fpc_pkg::fpc_pack_t'(fmt3_reg[5:4]); // [R7]
        end
    end

    // frc advance; alternate frames only in two-frame mode
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            frcPhase_reg <= 1'b0;
            frcStep <= 1'b0;
        end
        else
        begin
            frcStep <= 1'b0;
            if (flmRaw)
            begin
                frcPhase_reg <= !frcPhase_reg;
                frcStep <= !(tim.frcTwoFrame && fmt3_reg[`FPC_B_FRC3])
                    || frcPhase_reg; // [R9]
            end
        end
    end

    // horizontal compensation decisions
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            hComp <= 1'b0;
            hAutoCenter <= 1'b0;
            leftBorder <= 9'h000;
            textCompress <= 1'b0;
            force8Dot <= 1'b0;
            hDouble <= 1'b0;
        end
        else
        begin
            hComp <= panelMode && disp_reg[`FPC_B_EFCP] && hcmp_reg[0]; // [R15]
            hAutoCenter <= hComp && hcmp_reg[1]; // [R15]
            leftBorder <= (hComp && !hcmp_reg[1]) ? {1'b0, hlb_reg} + 9'h001
                : 9'h000; // [R19]
            textCompress <= hComp && hcmp_reg[2] && tim.textMode; // [R16]
            force8Dot <= hComp && hcmp_reg[2] && tim.textMode && tim.nineDot; // [R16]
            hDouble <= hComp && (tim.seqDouble || tim.cgaDouble
                || (hcmp_reg[5] && {1'b0, hDispEnd, 1'b0} <= {2'b00, hPanelSize})); // [R17]
        end
    end

    // vertical plan
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            vPlan <= '0;
        end
        else
        begin
            vPlan.center <= panelMode && disp_reg[`FPC_B_EFCP] && vcmp_reg[0]; // [R20]
            vPlan.autoCenter <= vPlan.center && vcmp_reg[1]; // [R20]
            vPlan.textStretch <= vPlan.center && vcmp_reg[2]; // [R21]
            vPlan.tallFont <= vPlan.center && vcmp_reg[2] && vcmp_reg[4]; // [R21]
            vPlan.secondFirst <= vPlan.center && vcmp_reg[2] && vcmp_reg[3]; // [R21]
            vPlan.repStretch <= vPlan.center && vcmp_reg[5]; // [R22]
            vPlan.repFirst <= vPlan.center && vcmp_reg[5] && vcmp_reg[6]; // [R22]
            vPlan.fastCenter <= vctr_reg[1:0] == 2'b11 && !vcmp_reg[`FPC_B_HOLD]; // [R23]
        end
    end

    a_standby_float: assert property (!stbySync[1] |=> !pixOe && !ctlOe) // [R1]
        else $error("pins driven in standby");
    a_host_ignored: assert property (standby |=> $stable(idx_reg) && $stable(pif_reg)) // [R1]
        else $error("write taken in standby");
    a_crt_inactive: assert property (!standby && !panelMode
        && pwr_reg[`FPC_B_CRTCTL] |=> pixOe && pixOut == 8'h00) // [R3]
        else $error("crt mode pins not inactive");
    a_blank_pol: assert property (vidMode == fpc_pkg::VID_DRIVE
        |=> blankOut == ((!$past(fpBlank)) ^ $past(pif_reg[0]))) // [R10]
        else $error("blank polarity wrong");
    a_no_vblank_lp: assert property (vidMode == fpc_pkg::VID_DRIVE && !pif_reg[1]
        && tim.vBlank |=> linePulseOut == $past(pif_reg[6])) // [R11]
        else $error("line pulse in vertical blank");
    a_clk_override: assert property (panelMode
        |=> dotClkSel == $past({pif_reg[5:4], pif_reg[3:2]})) // [R13]
        else $error("dot clock source not overridden");
    a_border_plus1: assert property (hComp && !hcmp_reg[1] && $stable(hlb_reg)
        |=> leftBorder == {1'b0, $past(hlb_reg)} + 9'h001) // [R19]
        else $error("left border not value plus one");
    a_hcomp_gate: assert property (!disp_reg[`FPC_B_EFCP] ##1 !disp_reg[`FPC_B_EFCP]
        |=> !hDouble && !textCompress && leftBorder == 9'h000) // [R15] [R25]
        else $error("horizontal compensation without enable");
    a_fast_center: assert property (vctr_reg[1:0] != 2'b11 |=> !vPlan.fastCenter) // [R23]
        else $error("fast centering outside field 11");
    a_sync_pol: assert property (panelMode |=> crtSyncPol == $past(hcmp_reg[7:6])) // [R18]
        else $error("crt sync polarity not overridden");

    c_standby: cover property (!stbySync[1] ##1 refreshReq);
    c_line_pulse: cover property (lpRaw && pif_reg[1] && tim.vBlank);
    c_double: cover property (hDouble && hcmp_reg[5]);
    c_frc_skip: cover property (flmRaw && tim.frcTwoFrame && fmt3_reg[`FPC_B_FRC3]);
endmodule

// [core/fpc_pkg.sv]
package fpc_pkg;
    // timing strobes from the display pipeline
    typedef struct packed {
        logic hBlank;
        logic vBlank;
        logic crtBlank;
        logic textMode;
        logic nineDot;
        logic seqDouble;
        logic cgaDouble;
        logic attrLineGfx;
        logic frcTwoFrame;
    } fpc_timing_t;
    // vertical compensation decisions
    typedef struct packed {
        logic center;
        logic autoCenter;
        logic textStretch;
        logic tallFont;
        logic secondFirst;
        logic repStretch;
        logic repFirst;
        logic fastCenter;
    } fpc_vplan_t;
    typedef enum logic [1:0] {PACK3, PACK4, PACKRSV, PACK4X} fpc_pack_t;
    typedef enum logic [1:0] {VID_DRIVE, VID_INACTIVE, VID_FLOAT} fpc_vid_t;
endpackage

// [core/fpc_refresh_pacer.sv]
`timescale 1ns/1ps
`include "fpc_cfg.svh"
module fpc_refresh_pacer (
    input wire logic clk, // dot clock
    input wire logic sys_rst, // async reset
    input wire logic standby, // standby active
    input wire logic paced, // 1: paced refresh
    input wire logic srcTick, // one-cycle source tick
    input wire logic [3:0] divider, // interval select
    output logic refreshReq, // refresh pulse
    output logic selfRefresh // self-refresh memories
);
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;

    // paced interval counts source ticks, value plus one
    always_comb
    begin
        cnt_next = cnt_reg + 4'h1;
        if (!standby || !paced || cnt_reg == divider)
        begin
            cnt_next = 4'h0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_reg <= 4'h0;
        end
        else if (srcTick || !standby || !paced)
        begin
            cnt_reg <= cnt_next;
        end
    end

    // one request per finished interval
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            refreshReq <= 1'b0;
            selfRefresh <= 1'b0;
        end
        else
        begin
            refreshReq <= standby && paced && srcTick && cnt_reg == divider; // [R2]
            selfRefresh <= standby && !paced; // [R2]
        end
    end

    a_self_mode: assert property (@(posedge clk) disable iff (sys_rst)
        standby && !paced |=> selfRefresh && !refreshReq) // [R2]
        else $error("self refresh not selected");
endmodule
